// file: verilog/lcdmc_pkg.sv
// Package with register layout, memory geometry and timing constants for the LCD memory block.
package lcdmc_pkg;

  // Display memory geometry.
  localparam int unsigned MEM_WORDS       = 48;
  localparam logic [7:0]  MEM_FIRST_ADDR  = 8'h00;
  localparam logic [7:0]  MEM_LAST_ADDR   = 8'h2f;
  localparam logic [7:0]  MEM_SECTOR      = 8'h04;

  // Sub-clock dividers.
  localparam int unsigned LCD_CLK_DIV     = 8;
  localparam int unsigned PUMP_DIV_MAX    = 128;

  // Register selectors on the special-register port.
  localparam logic [1:0]  SEL_WAVE_BIAS   = 2'h0;
  localparam logic [1:0]  SEL_PUMP_POWER  = 2'h1;
  localparam logic [1:0]  SEL_DUTY_BIAS   = 2'h2;

  // Implemented-bit masks and reset values.
  localparam logic [7:0]  WAVE_BIAS_MASK  = 8'hf7;
  localparam logic [7:0]  PUMP_POWER_MASK = 8'h0b;
  localparam logic [7:0]  DUTY_BIAS_MASK  = 8'he7;
  localparam logic [7:0]  WAVE_BIAS_RST   = 8'h00;
  localparam logic [7:0]  PUMP_POWER_RST  = 8'h00;
  localparam logic [7:0]  DUTY_BIAS_RST   = 8'h00;

  // Field positions in the first control register.
  localparam int unsigned WB_TYPE_BIT     = 7;
  localparam int unsigned WB_METHOD_BIT   = 6;
  localparam int unsigned WB_CPWR_LSB     = 4;
  localparam int unsigned WB_CURR_LSB     = 1;
  localparam int unsigned WB_ENABLE_BIT   = 0;
  // Field positions in the pump register.
  localparam int unsigned PP_SUPPLY_BIT   = 3;
  localparam int unsigned PP_VOLT_LSB     = 0;
  // Field positions in the third register.
  localparam int unsigned DB_PCK_LSB      = 5;
  localparam int unsigned DB_DUTY_LSB     = 1;
  localparam int unsigned DB_BIAS_BIT     = 0;

  typedef enum logic [1:0] {
    LCDMC_DUTY_4   = 2'b00,
    LCDMC_DUTY_6   = 2'b01,
    LCDMC_DUTY_8   = 2'b10,
    LCDMC_DUTY_BAD = 2'b11
  } lcdmc_duty_t;

  // Decoded configuration handed to the analog and waveform sections.
  typedef struct packed {
    logic        display_on;
    logic        wave_type_b;
    logic        bias_method_select;
    logic        cap_pump_on;
    logic [1:0]  cap_power_source;
    logic [1:0]  res_bias_current;
    logic        res_pump_on;
    logic [1:0]  pump_voltage_select;
    lcdmc_duty_t duty_select;
    logic        quarter_bias;
  } lcdmc_cfg_t;

  // CPU access to the display memory.
  typedef struct packed {
    logic       direct;
    logic       indirect;
    logic [7:0] sector;
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } lcdmc_cpu_req_t;

endpackage

// file: verilog/lcdmc_top.sv
// Display memory, control registers and clock dividers of the segment LCD driver.
`timescale 1ns/1ns

module lcdmc_top #(
  parameter int unsigned MEM_DEPTH = 48
) (
  // Clock and reset.
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_n_i,
  // Power mode and sub-clock, from outside this clock domain.
  input  wire logic                    sleep_i,
  input  wire logic                    sub_clk_i,
  // Control register port.
  input  wire logic                    reg_wr_i,
  input  wire logic [1:0]              reg_sel_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic      [7:0]              reg_rdata_o,
  // CPU display memory port.
  input  wire lcdmc_pkg::lcdmc_cpu_req_t cpu_req_i,
  output logic      [7:0]              cpu_rdata_o,
  output logic                         cpu_hit_o,
  // Driver scan port.
  input  wire logic [5:0]              scan_addr_i,
  output logic      [7:0]              scan_data_o,
  // Decoded configuration and clocks.
  output lcdmc_pkg::lcdmc_cfg_t        cfg_o,
  output logic                         lcd_reset_o,
  output logic                         lcd_clk_tick_o,
  output logic                         pump_clk_tick_o
);
  import lcdmc_pkg::*;

  // The address decode covers exactly the fixed window, so the depth cannot differ from it.
  if (MEM_DEPTH != MEM_WORDS)
  begin
    $error("lcdmc_top: MEM_DEPTH must equal the decoded window size");
  end

  logic [7:0] wave_bias_q;
  logic [7:0] pump_power_q;
  logic [7:0] duty_bias_q;
  logic [7:0] mem_q [MEM_DEPTH];
  logic [1:0] sleep_sync_q;
  logic [1:0] sub_sync_q;
  logic       sub_prev_q;
  logic [2:0] lcd_div_q;
  logic [6:0] pump_div_q;
  logic       lcd_run;
  logic       sub_rise;
  logic       cpu_hit;
  logic [7:0] duty_mask;
  logic [6:0] pump_tap;

  // Byte mask of the commons that exist in the selected duty.
  function automatic logic [7:0] duty_bits(input logic [1:0] duty);
    unique case (duty)
      LCDMC_DUTY_4: duty_bits = 8'h0f;
      LCDMC_DUTY_6: duty_bits = 8'h3f;
      LCDMC_DUTY_8: duty_bits = 8'hff;
      default:      duty_bits = 8'h0f;
    endcase
  endfunction

  assign duty_mask = duty_bits(duty_bias_q[DB_DUTY_LSB +: 2]);

  // Control registers; masked so unimplemented bits never hold a one.
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      wave_bias_q  <= WAVE_BIAS_RST;
      pump_power_q <= PUMP_POWER_RST;
      duty_bias_q  <= DUTY_BIAS_RST;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_sel_i)
        SEL_WAVE_BIAS:  wave_bias_q  <= reg_wdata_i & WAVE_BIAS_MASK;
        SEL_PUMP_POWER: pump_power_q <= reg_wdata_i & PUMP_POWER_MASK;
        SEL_DUTY_BIAS:  duty_bias_q  <= reg_wdata_i & DUTY_BIAS_MASK;
        default:        ;
      endcase
    end
  end

  always_comb
  begin
    unique case (reg_sel_i)
      SEL_WAVE_BIAS:  reg_rdata_o = wave_bias_q;
      SEL_PUMP_POWER: reg_rdata_o = pump_power_q;
      SEL_DUTY_BIAS:  reg_rdata_o = duty_bias_q;
      default:        reg_rdata_o = 8'h00;
    endcase
  end

  // Sleep and the sub-clock arrive asynchronously to the reference clock.
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      sleep_sync_q <= 2'h0;
      sub_sync_q   <= 2'h0;
      sub_prev_q   <= 1'b0;
    end
    else
    begin
      sleep_sync_q <= {sleep_sync_q[0], sleep_i};
      sub_sync_q   <= {sub_sync_q[0], sub_clk_i};
      sub_prev_q   <= sub_sync_q[1];
    end
  end

  assign sub_rise = sub_sync_q[1] & ~sub_prev_q;
  assign lcd_run  = wave_bias_q[WB_ENABLE_BIT] & ~sleep_sync_q[1];
  assign lcd_reset_o = ~lcd_run;

  // The driver section holds its commons and segments low while this is high.
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !lcd_run)
      lcd_div_q <= 3'h0;
    else if (sub_rise)
      lcd_div_q <= lcd_div_q + 3'h1;
  end

  assign lcd_clk_tick_o = sub_rise && lcd_div_q == 3'(LCD_CLK_DIV - 1) && lcd_run;

  // Pump divider: code c divides by 128 >> c, with the top code equal to /2.
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !lcd_run)
      pump_div_q <= 7'h00;
    else if (sub_rise)
      pump_div_q <= pump_div_q + 7'h01;
  end

  always_comb
  begin
    pump_tap = 7'h00;
    unique case (duty_bias_q[DB_PCK_LSB +: 3])
      3'h0: pump_tap = 7'(PUMP_DIV_MAX - 1);
      3'h1: pump_tap = 7'h3f;
      3'h2: pump_tap = 7'h1f;
      3'h3: pump_tap = 7'h0f;
      3'h4: pump_tap = 7'h07;
      3'h5: pump_tap = 7'h03;
      3'h6: pump_tap = 7'h01;
      3'h7: pump_tap = 7'h01;
    endcase
  end

  assign pump_clk_tick_o = sub_rise && lcd_run && wave_bias_q[WB_METHOD_BIT]
                           && ((pump_div_q & pump_tap) == pump_tap);

  // Decoded configuration; analog enables fall when the display is off.
  always_comb
  begin
    cfg_o.display_on          = lcd_run;
    cfg_o.wave_type_b         = wave_bias_q[WB_TYPE_BIT];
    cfg_o.bias_method_select  = wave_bias_q[WB_METHOD_BIT];
    cfg_o.cap_pump_on         = wave_bias_q[WB_METHOD_BIT] & lcd_run;
    cfg_o.cap_power_source    = wave_bias_q[WB_CPWR_LSB +: 2];
    cfg_o.res_bias_current    = wave_bias_q[WB_CURR_LSB +: 2];
    cfg_o.res_pump_on         = pump_power_q[PP_SUPPLY_BIT]
                                & ~wave_bias_q[WB_METHOD_BIT] & lcd_run;
    cfg_o.pump_voltage_select = pump_power_q[PP_VOLT_LSB +: 2];
    cfg_o.duty_select         = lcdmc_duty_t'(duty_bias_q[DB_DUTY_LSB +: 2]);
    cfg_o.quarter_bias        = duty_bias_q[DB_BIAS_BIT];
  end

  // Only sector 4 through a pointer, or the direct extended form, reaches memory.
  assign cpu_hit = (cpu_req_i.direct
                    || (cpu_req_i.indirect && cpu_req_i.sector == MEM_SECTOR))
                   && cpu_req_i.addr >= MEM_FIRST_ADDR
                   && cpu_req_i.addr <= MEM_LAST_ADDR;
  assign cpu_hit_o = cpu_hit;

  // One write port, two registered read ports: scan and CPU never wait.
  always_ff @(posedge ref_clk_i)
  begin
    if (cpu_hit && cpu_req_i.wr)
      mem_q[cpu_req_i.addr[5:0]] <= cpu_req_i.wdata & duty_mask;
  end

  // Unwritten memory content is undefined until software fills it.
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      cpu_rdata_o <= 8'h00;
      scan_data_o <= 8'h00;
    end
    else
    begin
      cpu_rdata_o <= cpu_hit ? (mem_q[cpu_req_i.addr[5:0]] & duty_mask) : 8'h00;
      if (!lcd_run)
        scan_data_o <= 8'h00;
      else if (32'(scan_addr_i) < MEM_DEPTH)
        scan_data_o <= mem_q[scan_addr_i] & duty_mask;
      else
        scan_data_o <= 8'h00;
    end
  end

endmodule

// file: tb/lcdmc_top_monitor.sv
// Port checker for the LCD memory block, bound to its top module.
`timescale 1ns/1ns
module lcdmc_mon
  import lcdmc_pkg::*;
(
  input wire logic           ref_clk_i,
  input wire logic           reset_n_i,
  input wire logic           reg_wr_i,
  input wire logic [1:0]     reg_sel_i,
  input wire logic [7:0]     reg_wdata_i,
  input wire logic [7:0]     reg_rdata_o,
  input wire lcdmc_cpu_req_t cpu_req_i,
  input wire logic [7:0]     cpu_rdata_o,
  input wire logic           cpu_hit_o,
  input wire logic [7:0]     scan_data_o,
  input wire lcdmc_cfg_t     cfg_o,
  input wire logic           lcd_reset_o,
  input wire logic           lcd_clk_tick_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_reset_tracks_on: assert property (lcd_reset_o == !cfg_o.display_on)
    else $error("lcd reset and display on disagree");
  chk_wave_write: assert property (reg_wr_i && reg_sel_i == SEL_WAVE_BIAS |=>
    reg_sel_i != SEL_WAVE_BIAS || reg_rdata_o == ($past(reg_wdata_i) & 8'hf7))
    else $error("first register readback wrong");
  chk_pump_unused: assert property (reg_sel_i == SEL_PUMP_POWER |->
    (reg_rdata_o & 8'hf4) == 8'h00)
    else $error("pump register unused bits set");
  chk_rpump_forced: assert property (cfg_o.res_pump_on |-> !cfg_o.bias_method_select)
    else $error("resistor pump on in capacitor mode");
  chk_scan_dark: assert property (!cfg_o.display_on ##1 !cfg_o.display_on |->
    scan_data_o == 8'h00)
    else $error("scan data while display off");
  chk_miss_zero: assert property (!cpu_hit_o |=> cpu_rdata_o == 8'h00)
    else $error("miss returned data");
  chk_wrong_sector: assert property (cpu_req_i.indirect && !cpu_req_i.direct &&
    cpu_req_i.sector != MEM_SECTOR |-> !cpu_hit_o)
    else $error("hit outside sector");
  chk_tick_pulse: assert property (lcd_clk_tick_o |=> !lcd_clk_tick_o [*3])
    else $error("lcd tick too wide");
  cov_hit_write: cover property (cpu_hit_o && cpu_req_i.wr);
  cov_tick: cover property (lcd_clk_tick_o);
  cov_dark: cover property ($rose(lcd_reset_o));
endmodule

bind lcdmc_top lcdmc_mon u_mon (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
  .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .cpu_req_i(cpu_req_i), .cpu_rdata_o(cpu_rdata_o), .cpu_hit_o(cpu_hit_o),
  .scan_data_o(scan_data_o), .cfg_o(cfg_o), .lcd_reset_o(lcd_reset_o),
  .lcd_clk_tick_o(lcd_clk_tick_o));

// file: tb/lcdmc_panel.sv
// Panel scan model: walks the display memory and keeps what each byte shows.
`timescale 1ns/1ns
module lcdmc_panel (
  input  wire logic       clk_i,
  input  wire logic [7:0] scan_data_i,
  output logic      [5:0] scan_addr_o,
  output logic            sub_clk_o
);
  logic [7:0] pix [48];
  logic [5:0] prev_q;
  logic [1:0] div_q;
  initial
  begin
    scan_addr_o = 6'h00;
    sub_clk_o = 1'b0;
    prev_q = 6'h00;
    div_q = 2'h0;
  end
  // Data arrives one cycle after its address, so it is filed under the previous one.
  always @(posedge clk_i)
  begin
    prev_q <= scan_addr_o;
    pix[prev_q] <= scan_data_i;
    scan_addr_o <= (scan_addr_o == 6'h2f) ? 6'h00 : scan_addr_o + 6'h01;
    div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    if (div_q == 2'h2)
      sub_clk_o <= ~sub_clk_o;
  end
endmodule

// file: tb/lcd_display_memory_and_control_test.sv
// Self-checking bench for the LCD memory block.
`timescale 1ns/1ns
module lcd_display_memory_and_control_test;
  import lcdmc_pkg::*;
  logic           clk = 1'b0, rst_n = 1'b0, slp = 1'b0, rwr = 1'b0;
  logic [1:0]     rsel = 2'h0;
  logic [7:0]     rwd = 8'h00, rrd, crd, sdat, m, w, a;
  lcdmc_cpu_req_t req = '0;
  lcdmc_cfg_t     cfg;
  logic           hit, lrst, ltk, ptk, sclk;
  logic [5:0]     sadr;
  int             err_count = 0, n_checks = 0, seed = 65383, t, e;
  logic [7:0]     mem [48], rv [4];
  logic [7:0]     msk [4] = '{WAVE_BIAS_MASK, PUMP_POWER_MASK, DUTY_BIAS_MASK, 8'h00};
  always #5 clk = ~clk;
  lcdmc_top u_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .sleep_i(slp), .sub_clk_i(sclk),
    .reg_wr_i(rwr), .reg_sel_i(rsel), .reg_wdata_i(rwd), .reg_rdata_o(rrd),
    .cpu_req_i(req), .cpu_rdata_o(crd), .cpu_hit_o(hit), .scan_addr_i(sadr),
    .scan_data_o(sdat), .cfg_o(cfg), .lcd_reset_o(lrst), .lcd_clk_tick_o(ltk),
    .pump_clk_tick_o(ptk));
  lcdmc_panel u_panel (.clk_i(clk), .scan_data_i(sdat), .scan_addr_o(sadr), .sub_clk_o(sclk));
  task test_done;
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wreg(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    rwr <= 1'b1;
    rsel <= s;
    rwd <= d;
    @(posedge clk);
    rwr <= 1'b0;
    #1;
  endtask
  task cpu(input logic ind, input logic [7:0] sec, ad, input logic wr, input logic [7:0] d);
    @(posedge clk);
    req <= '{~ind, ind, sec, ad, wr, d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task tick(input logic p, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (!(p ? ptk : ltk) && n < 1000);
    if (n >= 1000)
    begin
      err_count++;
      test_done;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      rsel <= s[1:0];
      #1 chk(rrd, 8'h00);
    end
    for (int i = 0; i < 12; i++)
    begin
      t = i % 4;
      w = $random(seed);
      rv[t] = w & msk[t];
      wreg(t[1:0], w);
      chk(rrd, rv[t]);
    end
    chk(cfg.wave_type_b, rv[0][7]);
    chk(cfg.cap_power_source, rv[0][5:4]);
    chk(cfg.res_bias_current, rv[0][2:1]);
    chk(cfg.display_on, rv[0][0]);
    chk(cfg.pump_voltage_select, rv[1][1:0]);
    chk(cfg.duty_select, rv[2][2:1]);
    chk(cfg.quarter_bias, rv[2][0]);
    wreg(2'h0, 8'h01);
    wreg(2'h1, 8'h08);
    chk(cfg.res_pump_on, 1'b1);
    wreg(2'h0, 8'h41);
    chk(cfg.res_pump_on, 1'b0);
    chk(cfg.cap_pump_on, 1'b1);
    wreg(2'h1, 8'h00);
    for (int d = 0; d < 4; d++)
    begin
      wreg(2'h2, {5'h00, d[1:0], 1'b0});
      wreg(2'h0, 8'h01);
      m = (d == 1) ? 8'h3f : (d == 2) ? 8'hff : 8'h0f;
      for (int i = 0; i < 6; i++)
      begin
        a = 8'({$random(seed)} % 48);
        w = $random(seed);
        mem[a] = w & m;
        cpu(i[0], MEM_SECTOR, a, 1'b1, w);
        cpu(~i[0], MEM_SECTOR, a, 1'b0, 8'h00);
        chk(crd, mem[a]);
      end
      cpu(1'b1, 8'h03, a, 1'b1, ~w);
      cpu(1'b0, MEM_SECTOR, 8'h30, 1'b0, 8'h00);
      chk(crd, 8'h00);
      cpu(1'b0, MEM_SECTOR, a, 1'b0, 8'h00);
      chk(crd, mem[a]);
      repeat (100) @(posedge clk);
      #1 chk(u_panel.pix[a], mem[a]);
    end
    tick(1'b0, t);
    tick(1'b0, t);
    chk(8'(t), 8'h30);
    // The panel model's sub-clock rises every 6 reference cycles.
    w = $random(seed);
    e = (w[7:5] == 3'h7) ? 12 : 6 * (128 >> w[7:5]);
    wreg(2'h2, {w[7:5], 5'h00});
    wreg(2'h0, 8'h41);
    tick(1'b1, t);
    tick(1'b1, t);
    chk(16'(t), 16'(e));
    @(posedge clk);
    slp <= 1'b1;
    repeat (100) @(posedge clk);
    #1 chk(lrst, 1'b1);
    chk(cfg.display_on, 1'b0);
    chk(u_panel.pix[a], 8'h00);
    test_done;
  end
  initial
  begin
    #1000000;
    err_count++;
    test_done;
  end
endmodule
